// ===== rtl/cpu8_pkg.sv
// Package for the 8-bit core's arithmetic, logic, load and store executor.
// Assumes an APB master with 32-bit data and a single 125 MHz clock.

package cpu8_pkg;

  // Register offsets on the APB bus.
  localparam logic [7:0] OFF_ACC   = 8'h00;
  localparam logic [7:0] OFF_XREG  = 8'h04;
  localparam logic [7:0] OFF_YREG  = 8'h08;
  localparam logic [7:0] OFF_PSW   = 8'h0C;
  localparam logic [7:0] OFF_PC    = 8'h10;
  localparam logic [7:0] OFF_ISSUE = 8'h14;
  localparam logic [7:0] OFF_STAT  = 8'h18;
  localparam logic [7:0] OFF_MADDR = 8'h1C;
  localparam logic [7:0] OFF_MDATA = 8'h20;

  // Status word bit positions.
  localparam int PSW_N = 7;
  localparam int PSW_V = 6;
  localparam int PSW_G = 5;
  localparam int PSW_B = 4;
  localparam int PSW_H = 3;
  localparam int PSW_I = 2;
  localparam int PSW_Z = 1;
  localparam int PSW_C = 0;
  localparam logic [7:0] PSW_RST = 8'h00;

  // Status register fields.
  localparam int STAT_BUSY  = 0;
  localparam int STAT_UNDEF = 1;
  localparam int STAT_LEN   = 8;

  // Operand columns of the opcode map (low five bits).
  localparam logic [4:0] COL_IMM  = 5'h04;
  localparam logic [4:0] COL_DP   = 5'h05;
  localparam logic [4:0] COL_DPX  = 5'h06;
  localparam logic [4:0] COL_ABS  = 5'h07;
  localparam logic [4:0] COL_IX   = 5'h14;
  localparam logic [4:0] COL_ABSY = 5'h15;
  localparam logic [4:0] COL_IDPX = 5'h16;
  localparam logic [4:0] COL_IDPY = 5'h17;
  localparam logic [4:0] COL_SA   = 5'h08;
  localparam logic [4:0] COL_SDP  = 5'h09;
  localparam logic [4:0] COL_SDPX = 5'h19;
  localparam logic [4:0] COL_SABS = 5'h18;
  localparam logic [4:0] COL_TCE  = 5'h0A;
  localparam logic [4:0] COL_TCO  = 5'h1A;

  // Operation rows (high three bits).
  localparam logic [2:0] ROW_ADC = 3'h0;
  localparam logic [2:0] ROW_SBC = 3'h1;
  localparam logic [2:0] ROW_CMP = 3'h2;
  localparam logic [2:0] ROW_OR  = 3'h3;
  localparam logic [2:0] ROW_AND = 3'h4;
  localparam logic [2:0] ROW_XOR = 3'h5;
  localparam logic [2:0] ROW_LDA = 3'h6;
  localparam logic [2:0] ROW_STA = 3'h7;
  localparam logic [2:0] ROW_INC = 3'h4;
  localparam logic [2:0] ROW_DEC = 3'h5;

  // Single opcodes.
  localparam logic [7:0] OP_MUL   = 8'h5B;
  localparam logic [7:0] OP_DIV   = 8'h9B;
  localparam logic [7:0] OP_DAA   = 8'hDF;
  localparam logic [7:0] OP_DAS   = 8'hCF;
  localparam logic [7:0] OP_XCN   = 8'hCE;
  localparam logic [7:0] OP_TST   = 8'h4C;
  localparam logic [7:0] OP_COM   = 8'h2C;
  localparam logic [7:0] OP_LDAXP = 8'hDB;
  localparam logic [7:0] OP_STAXP = 8'hFB;
  localparam logic [7:0] OP_LDM   = 8'hE4;
  localparam logic [7:0] OP_CPXI  = 8'h5E;
  localparam logic [7:0] OP_CPXD  = 8'h6C;
  localparam logic [7:0] OP_CPXA  = 8'h7C;
  localparam logic [7:0] OP_CPYI  = 8'h7E;
  localparam logic [7:0] OP_CPYD  = 8'h8C;
  localparam logic [7:0] OP_CPYA  = 8'h9C;
  localparam logic [7:0] OP_INCX  = 8'h8F;
  localparam logic [7:0] OP_DECX  = 8'hAF;
  localparam logic [7:0] OP_INCY  = 8'h9E;
  localparam logic [7:0] OP_DECY  = 8'hBE;
  localparam logic [7:0] OP_UPPER_PAGE_CALL = 8'h4F;
  localparam logic [7:0] OP_LDC   = 8'hCB;

  // Cycle counts.
  localparam logic [3:0] CYC_1  = 4'h1;
  localparam logic [3:0] CYC_2  = 4'h2;
  localparam logic [3:0] CYC_3  = 4'h3;
  localparam logic [3:0] CYC_4  = 4'h4;
  localparam logic [3:0] CYC_5  = 4'h5;
  localparam logic [3:0] CYC_6  = 4'h6;
  localparam logic [3:0] CYC_8  = 4'h8;
  localparam logic [3:0] CYC_9  = 4'h9;
  localparam logic [3:0] CYC_12 = 4'hC;

  // Call targets and limits.
  localparam logic [7:0]  UPAGE_HI   = 8'hFF;
  localparam logic [15:0] VECTOR_TABLE_CALL_BASE = 16'hFFC0;
  localparam int          MBIT_AW    = 12;

  // One issued instruction: opcode and up to two operand bytes.
  typedef struct packed {
    logic [7:0] op2;
    logic [7:0] op1;
    logic [7:0] opc;
  } cpu8_insn_t;

endpackage

// ===== rtl/cpu8_exec.sv
// Executor for the arithmetic, logic, shift, multiply, divide, load and store
// instructions of an 8-bit core, driven and observed over an APB slave.
// Assumes one clock, pclk, and that software issues one instruction at a time.
`timescale 1ns/1ns

module cpu8_exec #(
  parameter int MAW = 9
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]         acc, xr, yr, status_word;
  logic [15:0]        pc;
  logic [7:0]         mem [2**MAW];
  logic [MAW-1:0]     maddr;
  cpu8_pkg::cpu8_insn_t insn;
  logic               busy, undef;
  logic [3:0]         cnt;
  logic [1:0]         ilen;
  logic               commit;
  logic               wr_ok, setup, map_ok;

  // Execution results.
  logic [7:0]         next_acc, next_xr, next_yr, next_psw;
  logic [15:0]        next_pc;
  logic               next_undef, mem_we;
  logic [15:0]        ea;
  logic [7:0]         mem_wd;
  logic [3:0]         cyc;
  logic [1:0]         len;

  // Reads one data byte; the address wraps to the memory size.
  function automatic logic [7:0] rdm(input logic [15:0] a);
    rdm = mem[a[MAW-1:0]];
  endfunction

  // A one-cycle instruction commits at the first edge after issue, longer ones at count zero.
  // A write lands only if its setup cycle was not refused, so the answer and the effect agree.
  assign commit = busy && ((cnt == 4'h0) || ((cnt == 4'hF) && (cyc == cpu8_pkg::CYC_1)));
  assign setup  = psel && !penable;
  assign wr_ok  = psel && penable && pready && pwrite && !pslverr;

  // ---------------------------------------------------------------
  // Decode and execute
  // ---------------------------------------------------------------

  // Computes the effect of the held instruction, committed at its last cycle.
  always_comb
  begin
    logic [7:0]  o;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [4:0]  col;
    logic [2:0]  row;
    logic [15:0] dp;
    logic [15:0] ptr;
    logic [8:0]  s9;
    logic [7:0]  m;
    logic [7:0]  r;
    logic [15:0] p16;
    logic [15:0] q16;
    logic        nz, cf;
    o = insn.opc;
    b1 = insn.op1;
    b2 = insn.op2;
    col = o[4:0];
    row = o[7:5];
    dp = {7'h00, status_word[cpu8_pkg::PSW_G], b1};
    ptr = 16'h0000;
    s9 = 9'h000;
    m = 8'h00;
    r = 8'h00;
    p16 = 16'h0000;
    q16 = 16'h0000;
    nz = 1'b0;
    cf = 1'b0;
    next_acc = acc;
    next_xr = xr;
    next_yr = yr;
    next_psw = status_word;
    next_pc = pc;
    next_undef = 1'b0;
    mem_we = 1'b0;
    mem_wd = 8'h00;
    ea = dp;
    cyc = cpu8_pkg::CYC_1;
    len = 2'd1;
    // Effective address for the eight operand columns.
    unique case (col)
      cpu8_pkg::COL_DPX, cpu8_pkg::COL_SDPX: ea = {dp[15:8], b1 + xr};
      cpu8_pkg::COL_ABS, cpu8_pkg::COL_SABS: ea = {b2, b1};
      cpu8_pkg::COL_IX:   ea = {dp[15:8], xr};
      cpu8_pkg::COL_ABSY: ea = {b2, b1} + {8'h00, yr};
      cpu8_pkg::COL_IDPX:
      begin
        ptr = {dp[15:8], b1 + xr};
        ea = {rdm(ptr + 16'h0001), rdm(ptr)};
      end
      cpu8_pkg::COL_IDPY: ea = {rdm(dp + 16'h0001), rdm(dp)} + {8'h00, yr};
      default: ea = dp;
    endcase
    m = (col == cpu8_pkg::COL_IMM) ? b1 : rdm(ea);
    if ((col[3:0] >= 4'h4) && (col[3:0] <= 4'h7) && (o != cpu8_pkg::OP_LDM))
    begin
      // Operand fetch timing by mode; stores take one cycle more.
      unique case (col)
        cpu8_pkg::COL_IMM:  cyc = cpu8_pkg::CYC_2;
        cpu8_pkg::COL_DP:   cyc = cpu8_pkg::CYC_3;
        cpu8_pkg::COL_DPX:  cyc = cpu8_pkg::CYC_4;
        cpu8_pkg::COL_ABS:  cyc = cpu8_pkg::CYC_4;
        cpu8_pkg::COL_IX:   cyc = cpu8_pkg::CYC_3;
        cpu8_pkg::COL_ABSY: cyc = cpu8_pkg::CYC_5;
        default:            cyc = cpu8_pkg::CYC_6;
      endcase
      len = (col == cpu8_pkg::COL_IX) ? 2'd1 :
            (col == cpu8_pkg::COL_ABS || col == cpu8_pkg::COL_ABSY) ? 2'd3 : 2'd2;
      nz = 1'b1;
      unique case (row)
        cpu8_pkg::ROW_ADC, cpu8_pkg::ROW_SBC, cpu8_pkg::ROW_CMP:
        begin
          // Subtraction adds the complement; carry set means no borrow.
          r = (row == cpu8_pkg::ROW_ADC) ? m : ~m;
          cf = (row == cpu8_pkg::ROW_CMP) ? 1'b1 : status_word[cpu8_pkg::PSW_C];
          s9 = {1'b0, acc} + {1'b0, r} + {8'h00, cf};
          next_psw[cpu8_pkg::PSW_C] = s9[8];
          if (row != cpu8_pkg::ROW_CMP)
          begin
            next_acc = s9[7:0];
            next_psw[cpu8_pkg::PSW_V] = ~(acc[7] ^ r[7]) & (acc[7] ^ s9[7]);
            next_psw[cpu8_pkg::PSW_H] = acc[4] ^ r[4] ^ s9[4];
          end
          r = s9[7:0];
        end
        cpu8_pkg::ROW_OR:  r = acc | m;
        cpu8_pkg::ROW_AND: r = acc & m;
        cpu8_pkg::ROW_XOR: r = acc ^ m;
        cpu8_pkg::ROW_LDA: r = m;
        default:
        begin
          // Store row: memory write only, flags untouched.
          nz = 1'b0;
          mem_we = (col != cpu8_pkg::COL_IMM);
          mem_wd = acc;
          cyc = cyc + cpu8_pkg::CYC_1;
          next_undef = (col == cpu8_pkg::COL_IMM);
        end
      endcase
      if (row >= cpu8_pkg::ROW_OR && row <= cpu8_pkg::ROW_LDA)
        next_acc = r;
    end
    else if ((col == cpu8_pkg::COL_SA || col == cpu8_pkg::COL_SDP ||
              col == cpu8_pkg::COL_SDPX || col == cpu8_pkg::COL_SABS) && row <= 3'h5)
    begin
      // Shift, rotate, increment and decrement on A or memory.
      m = (col == cpu8_pkg::COL_SA) ? acc : rdm(ea);
      cf = status_word[cpu8_pkg::PSW_C];
      unique case (row)
        3'h0: {cf, r} = {m, 1'b0};
        3'h1: {cf, r} = {m, cf};
        3'h2: {r, cf} = {1'b0, m};
        3'h3: {r, cf} = {cf, m};
        3'h4: r = m + 8'h01;
        default: r = m - 8'h01;
      endcase
      if (row <= 3'h3)
        next_psw[cpu8_pkg::PSW_C] = cf;
      nz = 1'b1;
      cyc = (col == cpu8_pkg::COL_SA) ? cpu8_pkg::CYC_2 :
            (col == cpu8_pkg::COL_SDP) ? cpu8_pkg::CYC_4 : cpu8_pkg::CYC_5;
      len = (col == cpu8_pkg::COL_SA) ? 2'd1 : (col == cpu8_pkg::COL_SABS) ? 2'd3 : 2'd2;
      if (col == cpu8_pkg::COL_SA)
        next_acc = r;
      else
      begin
        mem_we = 1'b1;
        mem_wd = r;
      end
    end
    else if (col == cpu8_pkg::COL_TCE || col == cpu8_pkg::COL_TCO)
    begin
      // Vector number: row gives the even part, column 1A adds one.
      next_pc = cpu8_pkg::VECTOR_TABLE_CALL_BASE + {11'h000, row, col[4], 1'b0};
      cyc = cpu8_pkg::CYC_8;
    end
    else
    begin
      unique case (o)
        cpu8_pkg::OP_MUL:
        begin
          p16 = yr * acc;
          {next_yr, next_acc} = p16;
          next_psw[cpu8_pkg::PSW_N] = p16[15];
          next_psw[cpu8_pkg::PSW_Z] = (p16 == 16'h0000);
          cyc = cpu8_pkg::CYC_9;
        end
        cpu8_pkg::OP_DIV:
        begin
          // Divide by zero or a quotient above 8 bits sets overflow.
          if (xr == 8'h00)
          begin
            q16 = 16'hFFFF;
            p16 = {8'h00, acc};
          end
          else
          begin
            q16 = {yr, acc} / {8'h00, xr};
            p16 = {yr, acc} % {8'h00, xr};
          end
          next_acc = q16[7:0];
          next_yr = p16[7:0];
          next_psw[cpu8_pkg::PSW_V] = (q16[15:8] != 8'h00);
          next_psw[cpu8_pkg::PSW_H] = (yr[3:0] >= xr[3:0]);
          next_psw[cpu8_pkg::PSW_N] = q16[7];
          next_psw[cpu8_pkg::PSW_Z] = (q16[7:0] == 8'h00);
          cyc = cpu8_pkg::CYC_12;
        end
        cpu8_pkg::OP_DAA, cpu8_pkg::OP_DAS:
        begin
          r = acc;
          cf = status_word[cpu8_pkg::PSW_C];
          if (o == cpu8_pkg::OP_DAA)
          begin
            if (cf || acc > 8'h99)
            begin
              r = r + 8'h60;
              cf = 1'b1;
            end
            if (status_word[cpu8_pkg::PSW_H] || acc[3:0] > 4'h9)
              r = r + 8'h06;
          end
          else
          begin
            if (!cf || acc > 8'h99)
            begin
              r = r - 8'h60;
              cf = 1'b0;
            end
            if (!status_word[cpu8_pkg::PSW_H] || acc[3:0] > 4'h9)
              r = r - 8'h06;
          end
          next_acc = r;
          next_psw[cpu8_pkg::PSW_C] = cf;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_3;
        end
        cpu8_pkg::OP_XCN:
        begin
          r = {acc[3:0], acc[7:4]};
          next_acc = r;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_5;
        end
        cpu8_pkg::OP_TST:
        begin
          r = rdm(dp) - 8'h00;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_3;
          len = 2'd2;
        end
        cpu8_pkg::OP_COM:
        begin
          r = ~rdm(dp);
          mem_we = 1'b1;
          mem_wd = r;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_4;
          len = 2'd2;
        end
        cpu8_pkg::OP_CPXI, cpu8_pkg::OP_CPXD, cpu8_pkg::OP_CPXA,
        cpu8_pkg::OP_CPYI, cpu8_pkg::OP_CPYD, cpu8_pkg::OP_CPYA:
        begin
          // Low nibble E is immediate, C is direct page, upper bit 4 is absolute.
          m = (o[3:0] == 4'hE) ? b1 : o[4] ? rdm({b2, b1}) : rdm(dp);
          r = (o == cpu8_pkg::OP_CPXI || o == cpu8_pkg::OP_CPXD ||
               o == cpu8_pkg::OP_CPXA) ? xr : yr;
          s9 = {1'b0, r} + {1'b0, ~m} + 9'h001;
          r = s9[7:0];
          next_psw[cpu8_pkg::PSW_C] = s9[8];
          nz = 1'b1;
          cyc = (o[3:0] == 4'hE) ? cpu8_pkg::CYC_2 : o[4] ? cpu8_pkg::CYC_4 : cpu8_pkg::CYC_3;
          len = (o[3:0] == 4'hE || !o[4]) ? 2'd2 : 2'd3;
        end
        cpu8_pkg::OP_INCX, cpu8_pkg::OP_DECX:
        begin
          r = (o == cpu8_pkg::OP_INCX) ? xr + 8'h01 : xr - 8'h01;
          next_xr = r;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_2;
        end
        cpu8_pkg::OP_INCY, cpu8_pkg::OP_DECY:
        begin
          r = (o == cpu8_pkg::OP_INCY) ? yr + 8'h01 : yr - 8'h01;
          next_yr = r;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_2;
        end
        cpu8_pkg::OP_LDAXP:
        begin
          ea = {dp[15:8], xr};
          r = rdm(ea);
          next_acc = r;
          next_xr = xr + 8'h01;
          nz = 1'b1;
          cyc = cpu8_pkg::CYC_4;
        end
        cpu8_pkg::OP_STAXP:
        begin
          ea = {dp[15:8], xr};
          mem_we = 1'b1;
          mem_wd = acc;
          next_xr = xr + 8'h01;
          cyc = cpu8_pkg::CYC_4;
        end
        cpu8_pkg::OP_LDM:
        begin
          ea = dp;
          mem_we = 1'b1;
          mem_wd = b2;
          cyc = cpu8_pkg::CYC_5;
          len = 2'd3;
        end
        cpu8_pkg::OP_UPPER_PAGE_CALL:
        begin
          next_pc = {cpu8_pkg::UPAGE_HI, b1};
          cyc = cpu8_pkg::CYC_6;
          len = 2'd2;
        end
        cpu8_pkg::OP_LDC:
        begin
          // Operand: bit number in the top three bits, address in the low twelve bits.
          m = rdm({4'h0, b2[3:0], b1});
          next_psw[cpu8_pkg::PSW_C] = m[b2[7:5]];
          cyc = cpu8_pkg::CYC_4;
          len = 2'd3;
        end
        default: next_undef = 1'b1;
      endcase
    end
    if (nz)
    begin
      next_psw[cpu8_pkg::PSW_N] = r[7];
      next_psw[cpu8_pkg::PSW_Z] = (r == 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // Architectural registers
  // ---------------------------------------------------------------

  // Software writes while idle; the instruction commits at its last cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc <= 8'h00;
      xr <= 8'h00;
      yr <= 8'h00;
      status_word <= cpu8_pkg::PSW_RST;
      pc <= 16'h0000;
    end
    else if (commit && !next_undef)
    begin
      acc <= next_acc;
      xr <= next_xr;
      yr <= next_yr;
      status_word <= next_psw;
      pc <= next_pc;
    end
    else if (wr_ok)
    begin
      if (paddr == cpu8_pkg::OFF_ACC)
        acc <= pwdata[7:0];
      if (paddr == cpu8_pkg::OFF_XREG)
        xr <= pwdata[7:0];
      if (paddr == cpu8_pkg::OFF_YREG)
        yr <= pwdata[7:0];
      if (paddr == cpu8_pkg::OFF_PSW)
        status_word <= pwdata[7:0];
      if (paddr == cpu8_pkg::OFF_PC)
        pc <= pwdata[15:0];
    end
  end

  // Data memory has no reset; writes come from software or from a commit.
  always_ff @(posedge pclk)
  begin
    if (commit && mem_we && !next_undef)
      mem[ea[MAW-1:0]] <= mem_wd;
    else if (wr_ok && paddr == cpu8_pkg::OFF_MDATA)
      mem[maddr] <= pwdata[7:0];
  end

  // Issue sequencing: the instruction holds busy for its full cycle count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      insn <= '0;
      busy <= 1'b0;
      cnt <= 4'h0;
      undef <= 1'b0;
      ilen <= 2'd0;
      maddr <= '0;
    end
    else if (wr_ok && paddr == cpu8_pkg::OFF_ISSUE)
    begin
      insn <= pwdata[23:0];
      busy <= 1'b1;
      cnt <= 4'hF;
    end
    else if (busy)
    begin
      if (commit)
      begin
        busy <= 1'b0;
        undef <= next_undef;
        ilen <= len;
      end
      else if (cnt == 4'hF)
        cnt <= cyc - cpu8_pkg::CYC_2;
      else
        cnt <= cnt - 4'h1;
    end
    else if (wr_ok && paddr == cpu8_pkg::OFF_MADDR)
      maddr <= pwdata[MAW-1:0];
  end

  // ---------------------------------------------------------------
  // APB response
  // ---------------------------------------------------------------

  assign map_ok = (paddr <= cpu8_pkg::OFF_MDATA) && (paddr[1:0] == 2'b00);

  // Answer is prepared in the setup cycle, so each access has no wait state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pready <= 1'b1;
      pslverr <= !map_ok || (pwrite && (busy || paddr == cpu8_pkg::OFF_STAT));
      prdata <= 32'h0000_0000;
      if (!pwrite)
        unique case (paddr)
          cpu8_pkg::OFF_ACC:   prdata[7:0] <= acc;
          cpu8_pkg::OFF_XREG:  prdata[7:0] <= xr;
          cpu8_pkg::OFF_YREG:  prdata[7:0] <= yr;
          cpu8_pkg::OFF_PSW:   prdata[7:0] <= status_word;
          cpu8_pkg::OFF_PC:    prdata[15:0] <= pc;
          cpu8_pkg::OFF_ISSUE: prdata[23:0] <= insn;
          cpu8_pkg::OFF_STAT:  prdata[9:0] <= {ilen, 6'h00, undef, busy};
          cpu8_pkg::OFF_MADDR: prdata[MAW-1:0] <= maddr;
          cpu8_pkg::OFF_MDATA: prdata[7:0] <= mem[maddr];
          default:             prdata <= 32'h0000_0000;
        endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// ===== bench/cpu8_exec_checker.sv
// Checker of the executor's APB answers.
// Assumes it is bound to cpu8_exec and sees only its ports.
`timescale 1ns/1ns
module cpu8_exec_checker (
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB ports.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Every setup cycle is answered in the very next cycle.
  property p_zero_wait;
    psel && !penable |=> pready && psel && penable;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("Access phase not answered.");
  property p_rdy_phase;
    pready |-> psel && penable;
  endproperty
  a_rdy_phase: assert property (p_rdy_phase) else $error("Ready outside access phase.");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("Ready held two cycles.");
  property p_err_qual;
    pslverr |-> pready;
  endproperty
  a_err_qual: assert property (p_err_qual) else $error("Error without ready.");
  property p_unaligned;
    pready && (paddr[1:0] != 2'h0 || paddr > 8'h20) |-> pslverr;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("Bad address not refused.");
  property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h0000_0000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("Refused read not zero.");
  property p_stat_ro;
    pready && pwrite && paddr == cpu8_pkg::OFF_STAT |-> pslverr;
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("Status write not refused.");
  property p_psw_width;
    pready && !pwrite && paddr == cpu8_pkg::OFF_PSW |-> prdata[31:8] == 24'h00_0000;
  endproperty
  a_psw_width: assert property (p_psw_width) else $error("Status word too wide.");
endmodule

// ===== bench/cpu8_apb_mst.sv
// APB master model standing in for the software that issues instructions.
// Assumes a slave that raises pready; a hang is cut short by the bench timeout.
`timescale 1ns/1ns
module cpu8_apb_mst (
  // Clock.
  input  wire logic        pclk,
  // Request.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // Answer.
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero.
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end
  // One transfer; the request is held until pready is seen high at an edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== bench/testbench.sv
// Bench: loads registers, issues instructions over APB and compares results.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ns
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel, penable, pwrite, pready, pslverr, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [47:0] tv [17];
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  cpu8_exec DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cpu8_apb_mst m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Clock at 125 MHz and a hang limit.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    m.xfer(1'b0, a, 32'h0000_0000, q, e);
  endtask
  // Polls the busy flag; the bound covers the longest instruction.
  task automatic waitb();
    repeat (20)
    begin
      rd(cpu8_pkg::OFF_STAT);
      if (q[0] === 1'b0)
        break;
    end
  endtask
  task automatic iss(input logic [23:0] i);
    wr(cpu8_pkg::OFF_ISSUE, {8'h00, i});
    waitb();
  endtask
  // Row: opcode, operand, start A, start status, expected A, expected status.
  task automatic run(input logic [47:0] v);
    wr(cpu8_pkg::OFF_ACC, {24'h00_0000, v[31:24]});
    wr(cpu8_pkg::OFF_PSW, {24'h00_0000, v[23:16]});
    iss({8'h00, v[39:32], v[47:40]});
    rd(cpu8_pkg::OFF_ACC);
    chk("acc", q, {24'h00_0000, v[15:8]});
    rd(cpu8_pkg::OFF_PSW);
    chk("psw", q, {24'h00_0000, v[7:0]});
  endtask
  initial
  begin
    presetn = 1'b0;
    tv = '{48'h0401_7F01_81C8, 48'h2412_3501_2309, 48'h4405_0500_0503,
      48'h5E11_0000_0080, 48'h7E20_0000_0003, 48'h840F_F001_0003,
      48'h6401_8000_8180, 48'hA4FF_FF00_0002, 48'h0800_8100_0201,
      48'h4800_0100_0003, 48'h2800_8001_0101, 48'h6800_0100_0003,
      48'h8800_FF01_0003, 48'hA800_0000_FF80, 48'hCE00_1200_2100,
      48'hDF00_0A00_1000, 48'h0000_550F_550F};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wr(cpu8_pkg::OFF_XREG, 32'h0000_0010);
    wr(cpu8_pkg::OFF_YREG, 32'h0000_0020);
    foreach (tv[i])
      run(tv[i]);
    rd(cpu8_pkg::OFF_STAT);
    chk("undef", q, 32'h0000_0102);
    // Multiply then divide back, with busy seen during the divide.
    wr(cpu8_pkg::OFF_ACC, 32'h0000_0010);
    iss(24'h00_005B);
    rd(cpu8_pkg::OFF_YREG);
    chk("mul_y", q, 32'h0000_0002);
    wr(cpu8_pkg::OFF_ISSUE, 32'h0000_009B);
    rd(cpu8_pkg::OFF_STAT);
    chk("busy", q[0], 1'b1);
    waitb();
    rd(cpu8_pkg::OFF_ACC);
    chk("div_q", q, 32'h0000_0020);
    // Direct-page load, complement, test, store and post-increment load.
    wr(cpu8_pkg::OFF_MADDR, 32'h0000_0030);
    iss(24'h5A_30E4);
    rd(cpu8_pkg::OFF_MDATA);
    chk("ldm", q, 32'h0000_005A);
    iss(24'h00_302C);
    wr(cpu8_pkg::OFF_PSW, 32'h0000_0000);
    iss(24'h00_304C);
    rd(cpu8_pkg::OFF_MDATA);
    chk("com", q, 32'h0000_00A5);
    rd(cpu8_pkg::OFF_PSW);
    chk("tst", q, 32'h0000_0080);
    wr(cpu8_pkg::OFF_ACC, 32'h0000_003C);
    iss(24'h00_31E5);
    wr(cpu8_pkg::OFF_ACC, 32'h0000_0000);
    wr(cpu8_pkg::OFF_XREG, 32'h0000_0031);
    iss(24'h00_00DB);
    rd(cpu8_pkg::OFF_ACC);
    chk("sta_lda", q, 32'h0000_003C);
    rd(cpu8_pkg::OFF_XREG);
    chk("xinc", q, 32'h0000_0032);
    // Upper page call, table call 3 and a bit load into carry.
    iss(24'h00_344F);
    rd(cpu8_pkg::OFF_PC);
    chk("upper_page_call", q, 32'h0000_FF34);
    iss(24'h00_003A);
    rd(cpu8_pkg::OFF_PC);
    chk("vector_table_call", q, 32'h0000_FFC6);
    iss(24'h00_30CB);
    rd(cpu8_pkg::OFF_PSW);
    chk("ldc", q, 32'h0000_0001);
    rd(8'h24);
    chk("unmapped", {q[30:0], e}, 32'h0000_0001);
    summarize();
  end
endmodule
bind cpu8_exec cpu8_exec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));
